// file: hdl/drive_remap_pkg.sv
/*
  Constants, types and register map of the drive parameter register remap
  front end. Assumes one 125 MHz clock shared by the APB master, the drive
  parameter port and the network boot logic.
*/
package drive_remap_pkg;

  // Network register space
  localparam int REG_COUNT = 1500;            // Registers numbered 1..1500
  localparam int LOW_SPAN = 1000;             // Registers 1..1000 -> F000..F999
  localparam int HIGH_FIRST = 1001;           // First register of group A
  localparam int GROUP_SIZE = 100;            // Registers per lettered group
  localparam logic [3:0] PARAM_PAGE = 4'hf;   // Leading digit of every code
  localparam logic [3:0] FIRST_LETTER = 4'ha; // Second digit of group A
  localparam logic [15:0] PARAM_LOW = 16'hf000;
  localparam logic [15:0] PARAM_HIGH = 16'hffff;

  // Documented registers, as register numbers (byte address is 4x)
  localparam int TWO_WIRE_COMMAND_ONE = 32'h3e9;
  localparam int TWO_WIRE_FREQUENCY_REF = 32'h3ea;
  localparam int PANEL_OPERATION_WORD = 32'h3ec;
  localparam int FOUR_WIRE_COMMAND_ONE = 32'h3ed;
  localparam int FOUR_WIRE_FREQUENCY_REF = 32'h3ee;
  localparam int OPTION_COMMAND_ONE = 32'h3ef;
  localparam int OPTION_FREQUENCY_REF = 32'h3f0;
  localparam int ACCEL_DECEL_SETTING = 32'h3f2;
  localparam int PANEL_KEY_SELECT = 32'h3f3;
  localparam int EXTERNAL_COMM_SETTING = 32'h3f4;
  localparam int TWO_WIRE_COMMAND_TWO = 32'h3fd;
  localparam int FOUR_WIRE_COMMAND_TWO = 32'h3ff;
  localparam int OPTION_COMMAND_TWO = 32'h400;
  localparam int TORQUE_REF_A = 32'h407;
  localparam int TORQUE_REF_B = 32'h409;
  localparam int TORQUE_REF_C = 32'h40a;
  localparam int TERMINAL_OUTPUT_WORD = 32'h41b;
  localparam int METER_ANALOG_OUT_A = 32'h41c;
  localparam int METER_ANALOG_OUT_B = 32'h41d;

  // Control block byte addresses, above the register window
  localparam logic [15:0] CTRL_ADDR = 16'h2000;
  localparam logic [15:0] PASSWORD_ADDR = 16'h2004;
  localparam logic [15:0] SET_IP_ADDR = 16'h2008;
  localparam logic [15:0] SET_MASK_ADDR = 16'h200c;
  localparam logic [15:0] SET_GW_ADDR = 16'h2010;
  localparam logic [15:0] STATUS_ADDR = 16'h2014;
  localparam logic [15:0] ACT_IP_ADDR = 16'h2018;
  localparam logic [15:0] HWID_LO_ADDR = 16'h201c;
  localparam logic [15:0] HWID_HI_ADDR = 16'h2020;

  // Field positions
  localparam int CTRL_REBOOT_BIT = 0;
  localparam int CTRL_DHCP_BIT = 1;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_REBOOTING_BIT = 1;
  localparam int STAT_UNLOCKED_BIT = 2;
  localparam int STAT_DHCP_BIT = 3;
  localparam int STAT_DEFAULT_BIT = 4;

  // Reset values and fixed addresses
  localparam logic [31:0] DEFAULT_IP = 32'hc0a8_1066; // 192.168.16.102
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Restart time
  localparam longint REBOOT_TIME_S = 30;
  localparam longint CLK_HZ = 125_000_000;
  localparam longint REBOOT_CYC = REBOOT_TIME_S * CLK_HZ;

  // Boot and restart states
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_DHCP = 2'b01,
    ST_READY = 2'b10,
    ST_REBOOT = 2'b11
  } net_state_e;

  // One parameter access toward the drive
  typedef struct packed {
    logic we;
    logic [15:0] param;
    logic [15:0] wdata;
  } drv_cmd_s;

  // Address settings as held by the drive
  typedef struct packed {
    logic [31:0] ip;
    logic [31:0] mask;
    logic [31:0] gw;
    logic dhcp;
    logic static_valid;
  } net_cfg_s;

endpackage : drive_remap_pkg

// file: hdl/drive_param_register_remap.sv
/*
  APB front end that turns network register numbers into drive parameter
  accesses, plus boot-time address selection, password lock, restart and
  discovery answer. Assumes the drive port, address settings and DHCP engine
  run on clk_i and that the drive acks each request one or more cycles later.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module drive_param_register_remap #(
  parameter logic [31:0] REBOOT_CYCLES = 32'(drive_remap_pkg::REBOOT_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic drv_req_o,
  output drive_remap_pkg::drv_cmd_s drv_cmd_o,
  input wire logic drv_ack_i,
  input wire logic [15:0] drv_rdata_i,
  input wire drive_remap_pkg::net_cfg_s cfg_i,
  input wire logic [47:0] hardware_network_identifier_i,
  input wire logic [31:0] password_i,
  output drive_remap_pkg::net_cfg_s store_o,
  output logic store_valid_o,
  output logic dhcp_req_o,
  input wire logic dhcp_done_i,
  input wire logic dhcp_fail_i,
  input wire logic [31:0] dhcp_ip_i,
  output logic [31:0] act_ip_o,
  output logic rebooting_o,
  input wire logic disc_req_i,
  output logic disc_ack_o,
  output logic [15:0] cmd_word_o,
  output logic [15:0] freq_ref_o
);
  import drive_remap_pkg::*;

  // Register number to drive parameter code, digit by digit
  function automatic logic [15:0] reg_to_param(input logic [10:0] num);
    logic [10:0] idx;
    logic [3:0] lead;
    idx = 11'd0;
    lead = 4'h0;
    if (num <= 11'(LOW_SPAN)) begin
      idx = num - 11'd1;
      lead = 4'(idx / 11'd100);
    end else begin
      idx = num - 11'(HIGH_FIRST);
      lead = FIRST_LETTER + 4'(idx / 11'(GROUP_SIZE));
    end
    reg_to_param = {PARAM_PAGE, lead, 4'((idx / 11'd10) % 11'd10),
                    4'(idx % 11'd10)};
  endfunction : reg_to_param

  // Bus phase and address decode
  wire access = psel_i & penable_i & ~pready_o;
  wire in_window = (paddr_i[15:13] == 3'b000);
  wire [10:0] reg_num = paddr_i[12:2];
  wire num_ok = (reg_num != 11'd0) && (reg_num <= 11'(REG_COUNT));
  wire win_go = access & in_window & num_ok;
  wire win_bad = access & in_window & ~num_ok;
  wire ctl_go = access & ~in_window;

  // Control state
  net_state_e state_reg, state_next;
  logic unlocked_reg; // Set by a matching password
  logic drv_busy_reg; // A drive access is outstanding
  logic [10:0] num_q_reg; // Register number of the outstanding access
  logic using_dhcp_reg; // Active address came from DHCP
  logic default_reg; // Fell back to the built-in address
  logic [31:0] boot_cnt_reg; // Restart timer
  net_cfg_s boot_cfg_reg; // Settings caught at boot

  // Control register decode
  wire is_ctrl = (paddr_i == CTRL_ADDR);
  wire is_pass = (paddr_i == PASSWORD_ADDR);
  wire is_ip = (paddr_i == SET_IP_ADDR);
  wire is_mask = (paddr_i == SET_MASK_ADDR);
  wire is_gw = (paddr_i == SET_GW_ADDR);
  wire is_stat = (paddr_i == STATUS_ADDR);
  wire is_act = (paddr_i == ACT_IP_ADDR);
  wire is_hlo = (paddr_i == HWID_LO_ADDR);
  wire is_hhi = (paddr_i == HWID_HI_ADDR);
  wire is_settings = is_ctrl | is_ip | is_mask | is_gw;
  wire is_ro = is_stat | is_act | is_hlo | is_hhi;
  wire mapped = is_settings | is_pass | is_ro;
  // Locked settings writes and any write to read-only words are refused
  wire ctl_err = ~mapped | (pwrite_i & is_ro) |
                 (pwrite_i & is_settings & ~unlocked_reg);
  wire ctl_wr = ctl_go & pwrite_i & ~ctl_err;
  wire reboot_go = ctl_wr & is_ctrl & pwdata_i[CTRL_REBOOT_BIT];

  // Status word
  wire [31:0] status_word = {27'h0, default_reg, using_dhcp_reg,
                             unlocked_reg, (state_reg == ST_REBOOT),
                             (state_reg == ST_READY)};

  // Read mux for the control block
  wire [31:0] ctl_rdata =
    is_ctrl ? {30'h0, store_o.dhcp, 1'b0} :
    is_ip ? store_o.ip :
    is_mask ? store_o.mask :
    is_gw ? store_o.gw :
    is_stat ? status_word :
    is_act ? act_ip_o :
    is_hlo ? hardware_network_identifier_i[31:0] :
    is_hhi ? {16'h0, hardware_network_identifier_i[47:32]} : ZERO_WORD;

  // Drive request launch and completion
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drv_req_o <= 1'b0;
      drv_busy_reg <= 1'b0;
      drv_cmd_o <= '0;
      num_q_reg <= 11'd0;
    end else begin
      drv_req_o <= 1'b0;
      if (win_go && !drv_busy_reg) begin
        // Forward every in-range number; unused ones the drive just absorbs
        drv_req_o <= 1'b1;
        drv_busy_reg <= 1'b1;
        drv_cmd_o <= '{we: pwrite_i, param: reg_to_param(reg_num),
                       wdata: pwdata_i[15:0]};
        num_q_reg <= reg_num;
      end else if (drv_busy_reg && drv_ack_i) begin
        drv_busy_reg <= 1'b0;
      end
    end
  end

  // Bus answer: one cycle for control and refused numbers, drive ack for in-range numbers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= ZERO_WORD;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      if (win_bad) begin
        pready_o <= 1'b1;
        pslverr_o <= 1'b1;
        prdata_o <= ZERO_WORD;
      end else if (ctl_go) begin
        pready_o <= 1'b1;
        pslverr_o <= ctl_err;
        prdata_o <= ctl_rdata;
      end else if (access && drv_busy_reg && drv_ack_i) begin
        pready_o <= 1'b1;
        prdata_o <= {16'h0, drv_rdata_i};
      end
    end
  end

  // Shadows of the option command and frequency words
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_word_o <= 16'h0;
      freq_ref_o <= 16'h0;
    end else if (drv_busy_reg && drv_ack_i && drv_cmd_o.we) begin
      if (num_q_reg == 11'(OPTION_COMMAND_ONE)) begin
        cmd_word_o <= drv_cmd_o.wdata;
      end
      if (num_q_reg == 11'(OPTION_FREQUENCY_REF)) begin
        freq_ref_o <= drv_cmd_o.wdata;
      end
    end
  end

  // Password lock; a restart locks again
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unlocked_reg <= 1'b0;
    end else if (state_reg == ST_REBOOT) begin
      unlocked_reg <= 1'b0;
    end else if (ctl_go && pwrite_i && is_pass) begin
      unlocked_reg <= (pwdata_i == password_i);
    end
  end

  // New settings go to the drive store; they act only after a restart
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      store_o <= '0;
      store_valid_o <= 1'b0;
    end else begin
      store_valid_o <= 1'b0;
      if (ctl_wr && is_settings && !is_ctrl) begin
        store_valid_o <= 1'b1;
        store_o.static_valid <= 1'b1;
        if (is_ip) store_o.ip <= pwdata_i;
        if (is_mask) store_o.mask <= pwdata_i;
        if (is_gw) store_o.gw <= pwdata_i;
      end else if (ctl_wr && is_ctrl) begin
        store_valid_o <= 1'b1;
        store_o.dhcp <= pwdata_i[CTRL_DHCP_BIT];
      end
    end
  end

  // Boot and restart sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_BOOT: state_next = boot_cfg_reg.dhcp ? ST_DHCP : ST_READY;
      ST_DHCP: if (dhcp_done_i || dhcp_fail_i) state_next = ST_READY;
      ST_READY: if (reboot_go) state_next = ST_REBOOT;
      ST_REBOOT: if (boot_cnt_reg == 32'd0) state_next = ST_BOOT;
      default: state_next = ST_BOOT;
    endcase
  end

  // State register and restart timer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_REBOOT;
      boot_cnt_reg <= 32'd0;
    end else begin
      state_reg <= state_next;
      if (reboot_go && state_reg == ST_READY) begin
        boot_cnt_reg <= REBOOT_CYCLES - 32'd1;
      end else if (boot_cnt_reg != 32'd0) begin
        boot_cnt_reg <= boot_cnt_reg - 32'd1;
      end
    end
  end

  // Settings are caught once per boot, never while running
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_cfg_reg <= '0;
    end else if (state_reg == ST_REBOOT && state_next == ST_BOOT) begin
      boot_cfg_reg <= cfg_i;
    end
  end

  // Active address selection with static fallback
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_ip_o <= ZERO_WORD;
      using_dhcp_reg <= 1'b0;
      default_reg <= 1'b0;
      dhcp_req_o <= 1'b0;
    end else begin
      dhcp_req_o <= (state_reg == ST_BOOT) && boot_cfg_reg.dhcp;
      if (state_reg == ST_DHCP && dhcp_done_i) begin
        act_ip_o <= dhcp_ip_i;
        using_dhcp_reg <= 1'b1;
        default_reg <= 1'b0;
      end else if ((state_reg == ST_DHCP && dhcp_fail_i) ||
                   (state_reg == ST_BOOT && !boot_cfg_reg.dhcp)) begin
        // No stored address ever: the built-in one is used
        act_ip_o <= boot_cfg_reg.static_valid ? boot_cfg_reg.ip
                                              : DEFAULT_IP;
        using_dhcp_reg <= 1'b0;
        default_reg <= ~boot_cfg_reg.static_valid;
      end
    end
  end

  // Restart flag and discovery answer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rebooting_o <= 1'b1;
      disc_ack_o <= 1'b0;
    end else begin
      rebooting_o <= (state_next == ST_REBOOT);
      // No subnet check, so a misconfigured unit can still be found
      disc_ack_o <= disc_req_i;
    end
  end

  // Checks
  a_low_map: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    drv_req_o && num_q_reg <= 11'(LOW_SPAN) |->
    drv_cmd_o.param[15:12] == PARAM_PAGE &&
    drv_cmd_o.param[11:8] <= 4'h9)
    else $error("low register mapped outside F000-F999");

  a_high_map: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    drv_req_o && num_q_reg > 11'(LOW_SPAN) |->
    drv_cmd_o.param[11:8] == FIRST_LETTER +
    4'((num_q_reg - 11'(HIGH_FIRST)) / 11'(GROUP_SIZE)))
    else $error("high register mapped to wrong group");

  a_range_reject: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    win_bad |=> pready_o && pslverr_o && !drv_req_o)
    else $error("out of range register not rejected");

  a_unused_ok: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    access && drv_busy_reg && drv_ack_i |=> pready_o && !pslverr_o)
    else $error("in range register completed with error");

  a_hwid_ro: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctl_go && pwrite_i && (is_hlo || is_hhi) |=> pslverr_o)
    else $error("identifier write not refused");

  a_lock_reboot: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_reg == ST_READY && $past(state_reg) == ST_READY &&
    !$past(unlocked_reg) |-> state_next != ST_REBOOT)
    else $error("reboot accepted while locked");

  a_reboot_state: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reboot_go && state_reg == ST_READY |=>
    rebooting_o && !status_word[STAT_READY_BIT])
    else $error("reboot not reported");

  a_cfg_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_reg == ST_READY |=> $stable(boot_cfg_reg))
    else $error("settings resampled while running");

  a_boot_dhcp: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_reg == ST_BOOT && boot_cfg_reg.dhcp |=>
    dhcp_req_o ##0 state_reg == ST_DHCP)
    else $error("DHCP not requested first");

  a_disc_ans: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    disc_req_i |=> disc_ack_o)
    else $error("discovery not answered");

endmodule : drive_param_register_remap
`default_nettype wire

// file: verif/drive_param_model.sv
/*
  Behavioural model of the drive's parameter store behind the remap block.
  Assumes one request at a time and the shared 125 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module drive_param_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic req_i,
  input wire drive_remap_pkg::drv_cmd_s cmd_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  import drive_remap_pkg::*;
  logic [15:0] mem [logic [15:0]]; // Any code F000..FFFF can hold a word
  int wait_q; // Cycles left before the answer
  int lat_sel; // Rotates latency 1..7 so both fast and slow answers occur
  // Answer each request later, with data only in the ack cycle
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      wait_q <= 0;
      lat_sel <= 0;
      rdata_o <= 16'h5a5a;
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o; // Idle data keeps moving, never a stale match
      if (req_i) begin
        wait_q <= 1 + lat_sel;
        lat_sel <= (lat_sel + 3) % 7;
      end else if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end else if (wait_q == 1) begin
        wait_q <= 0;
        ack_o <= 1'b1;
        if (cmd_i.we) begin
          mem[cmd_i.param] = cmd_i.wdata;
          rdata_o <= cmd_i.wdata;
        end else begin
          rdata_o <= mem.exists(cmd_i.param) ? mem[cmd_i.param] : 16'h0000;
        end
      end
    end
  end
endmodule : drive_param_model
`default_nettype wire

// file: verif/drive_param_register_remap_tb.sv
/*
  Self-checking bench for the register remap front end: mapping, refusals,
  command words, identifier, discovery, boot and restart.
  Assumes the package and the drive model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module drive_param_register_remap_tb;
  import drive_remap_pkg::*;
  logic clk_i = 0;
  logic rst_b_i = 0;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic disc_req = 0;
  logic dhcp_fail = 0;
  logic dhcp_done = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, act_ip;
  logic pready, pslverr, drv_req, drv_ack, store_valid, dhcp_req;
  logic rebooting, disc_ack, last_we;
  logic [15:0] drv_rdata, cmd_word, freq_ref, last_param;
  drv_cmd_s drv_cmd;
  net_cfg_s store;
  // Boot with DHCP selected and no static address stored yet
  net_cfg_s cfg = {32'h0a00_0005, 32'hffff_ff00, 32'h0a00_0001, 2'b10};
  logic [47:0] hwid = 48'h0012_3456_789a; // Arbitrary value
  logic [31:0] pass_key = 32'h0070_7764; // Arbitrary value, three letters
  int num_errors = 0;
  int n_tests = 0;
  int n_req = 0;
  int n_store = 0;

  always #4 clk_i = ~clk_i;

  // Record every access forwarded to the drive
  always @(posedge clk_i) begin
    if (drv_req) begin
      n_req <= n_req + 1;
      last_param <= drv_cmd.param;
      last_we <= drv_cmd.we;
    end
    // Count settings handed to the drive store
    if (store_valid) begin
      n_store <= n_store + 1;
    end
  end

  drive_param_register_remap #(.REBOOT_CYCLES(32'd20))
      drive_param_register_remap_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .drv_req_o(drv_req),
    .drv_cmd_o(drv_cmd), .drv_ack_i(drv_ack), .drv_rdata_i(drv_rdata),
    .cfg_i(cfg), .hardware_network_identifier_i(hwid),
    .password_i(pass_key), .store_o(store),
    .store_valid_o(store_valid), .dhcp_req_o(dhcp_req),
    .dhcp_done_i(dhcp_done),
    .dhcp_fail_i(dhcp_fail), .dhcp_ip_i(32'h0a00_0063), .act_ip_o(act_ip),
    .rebooting_o(rebooting), .disc_req_i(disc_req), .disc_ack_o(disc_ack),
    .cmd_word_o(cmd_word), .freq_ref_o(freq_ref));

  drive_param_model drive_param_model_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(drv_req), .cmd_i(drv_cmd),
    .ack_o(drv_ack), .rdata_o(drv_rdata));

  task automatic end_sim();
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic [15:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int i;
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge clk_i);
      if (pready) break;
    end
    if (i == 60) begin
      chk(0, 1, "bus answer timeout");
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Wait for the address request, refuse it, count the wait
  task automatic dhcp_fail_once(output int c);
    for (c = 0; c < 200; c++) begin
      @(posedge clk_i);
      if (dhcp_req) break;
    end
    if (c == 200) begin
      chk(0, 1, "no address request");
      end_sim();
    end
    dhcp_fail <= 1'b1;
    @(posedge clk_i);
    dhcp_fail <= 1'b0;
  endtask : dhcp_fail_once

  // Expected parameter code of a register number, from the mapping table
  function automatic logic [15:0] exp_param(input int n);
    int m;
    m = (n <= 1000) ? n - 1 : n - 1001;
    return {4'hf, (n <= 1000) ? 4'(m / 100) : 4'(10 + m / 100),
            4'(m / 10 % 10), 4'(m % 10)};
  endfunction : exp_param

  task automatic t_boot();
    int c;
    logic [31:0] q;
    logic e;
    dhcp_fail_once(c);
    @(posedge clk_i);
    chk(act_ip, DEFAULT_IP, "default address");
    apb(ACT_IP_ADDR, 1'b0, 32'h0, q, e);
    chk(q, DEFAULT_IP, "address read");
    apb(STATUS_ADDR, 1'b0, 32'h0, q, e);
    chk(q[4:3], 2'b10, "built-in address flags");
  endtask : t_boot

  task automatic t_map();
    int regs[10] = '{1, 456, 1000, 1001, 1003, 1101, 1201, 1301, 1401, 1500};
    int c;
    logic [31:0] q;
    logic e;
    logic [15:0] d;
    foreach (regs[k]) begin
      d = 16'(regs[k]) ^ 16'h3c00;
      apb(16'(regs[k] * 4), 1'b1, {16'habcd, d}, q, e);
      chk(e, 0, "window write error");
      chk(last_param, exp_param(regs[k]), "parameter code");
      chk(last_we, 1, "write direction");
      apb(16'(regs[k] * 4), 1'b0, 32'h0, q, e);
      chk(q, {16'h0000, d}, "read back");
    end
    c = n_req;
    apb(16'h0000, 1'b1, 32'h0, q, e);
    chk(e, 1, "register zero");
    apb(16'(1501 * 4), 1'b0, 32'h0, q, e);
    chk(e, 1, "register 1501");
    chk(n_req, c, "refused access forwarded");
  endtask : t_map

  task automatic t_cmd();
    logic [31:0] q;
    logic e;
    apb(16'(1007 * 4), 1'b1, 32'h0000_0400, q, e);
    chk(last_param, 16'hfa06, "command code");
    apb(16'(1008 * 4), 1'b1, 32'h0000_1f40, q, e);
    chk(cmd_word, 16'h0400, "run command");
    chk(freq_ref, 16'h1f40, "80.00 Hz reference");
  endtask : t_cmd

  task automatic t_hwid();
    logic [31:0] q;
    logic e;
    apb(HWID_LO_ADDR, 1'b0, 32'h0, q, e);
    chk(q, hwid[31:0], "identifier low");
    apb(HWID_HI_ADDR, 1'b1, 32'hffff_ffff, q, e);
    chk(e, 1, "identifier write");
    apb(HWID_HI_ADDR, 1'b0, 32'h0, q, e);
    chk(q, {16'h0000, hwid[47:32]}, "identifier high");
  endtask : t_hwid

  task automatic t_disc();
    @(posedge clk_i);
    disc_req <= 1'b1;
    @(posedge clk_i);
    disc_req <= 1'b0;
    @(posedge clk_i);
    chk(disc_ack, 1, "discovery answer");
  endtask : t_disc

  task automatic t_reboot();
    int c;
    logic [31:0] q;
    logic e;
    apb(CTRL_ADDR, 1'b1, 32'h1, q, e);
    chk(e, 1, "reboot while locked");
    apb(SET_IP_ADDR, 1'b1, 32'h0a01_0203, q, e);
    chk(e, 1, "settings write while locked");
    // Same letters in the wrong case must not unlock
    apb(PASSWORD_ADDR, 1'b1, 32'h0050_5744, q, e);
    apb(CTRL_ADDR, 1'b1, 32'h1, q, e);
    chk(e, 1, "reboot after wrong case");
    chk(n_store, 0, "refused settings stored");
    apb(PASSWORD_ADDR, 1'b1, pass_key, q, e);
    apb(SET_IP_ADDR, 1'b1, 32'h0a01_0203, q, e);
    chk(e, 0, "settings write unlocked");
    apb(STATUS_ADDR, 1'b0, 32'h0, q, e);
    chk(q[STAT_UNLOCKED_BIT], 1, "unlocked");
    chk(n_store, 1, "settings store pulse");
    chk(store.ip, 32'h0a01_0203, "stored address");
    cfg <= {32'h0a01_0203, 32'hffff_0000, 32'h0a01_0001, 2'b11};
    repeat (3) @(posedge clk_i);
    chk(act_ip, DEFAULT_IP, "settings taken while running");
    apb(CTRL_ADDR, 1'b1, 32'h1, q, e);
    chk(e, 0, "reboot accepted");
    chk(rebooting, 1, "rebooting output");
    apb(STATUS_ADDR, 1'b0, 32'h0, q, e);
    chk(q[STAT_REBOOTING_BIT], 1, "rebooting reported");
    dhcp_fail_once(c);
    chk(c >= 16, 1, "restart too short");
    @(posedge clk_i);
    chk(act_ip, 32'h0a01_0203, "stored static fallback");
    apb(STATUS_ADDR, 1'b0, 32'h0, q, e);
    chk(q[2:0], 3'b001, "ready and locked");
    chk(rebooting, 0, "rebooting output cleared");
  endtask : t_reboot

  // A second restart where the address server answers: its address wins
  task automatic t_dhcp();
    int c;
    logic [31:0] q;
    logic e;
    apb(PASSWORD_ADDR, 1'b1, pass_key, q, e);
    apb(CTRL_ADDR, 1'b1, 32'h3, q, e);
    chk(e, 0, "reboot with DHCP select");
    chk(store.dhcp, 1, "DHCP selection stored");
    for (c = 0; c < 200; c++) begin
      @(posedge clk_i);
      if (dhcp_req) break;
    end
    if (c == 200) begin
      chk(0, 1, "no address request after restart");
      end_sim();
    end
    dhcp_done <= 1'b1;
    @(posedge clk_i);
    dhcp_done <= 1'b0;
    @(posedge clk_i);
    chk(act_ip, 32'h0a00_0063, "DHCP address");
    apb(STATUS_ADDR, 1'b0, 32'h0, q, e);
    chk(q[4:3], 2'b01, "DHCP source flags");
  endtask : t_dhcp

  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_boot();
    t_map();
    t_cmd();
    t_hwid();
    t_disc();
    t_reboot();
    t_dhcp();
    end_sim();
  end
endmodule : drive_param_register_remap_tb
`default_nettype wire
